// ===== rtl/sim_pkg.sv
package sim_pkg;

    // ************************************************************
    // configuration map, byte offsets in configuration space
    // ************************************************************
    localparam logic [7:0] OFS_COMMAND_WORD      = 8'h04;
    localparam logic [7:0] OFS_MSI_CONTROL       = 8'h62;
    localparam logic [7:0] OFS_MSI_ADDRESS_LOW   = 8'h64;
    localparam logic [7:0] OFS_MSI_ADDRESS_HIGH  = 8'h68;
    localparam logic [7:0] OFS_MSI_DATA_VALUE    = 8'h6c;
    localparam logic [7:0] OFS_BUS_CLOCK_CONTROL = 8'hd8;
    localparam logic [7:0] OFS_SERIAL_FORMAT     = 8'he0;
    localparam logic [7:0] OFS_TRIGGER_SELECT    = 8'he2;
    localparam logic [7:0] OFS_LEVEL_STATUS      = 8'he4;

    // ************************************************************
    // field positions and reset values
    // ************************************************************
    localparam int          POS_BUS_MASTER_ENABLE  = 2;
    localparam int          POS_SINGLE_VECTOR_EN   = 0;
    localparam int          POS_MULTI_VECTOR_LO    = 4;
    localparam int          POS_MULTI_VECTOR_CAP   = 1;
    localparam logic [2:0]  MULTI_VECTOR_CAPABLE   = 3'h4;
    localparam logic [6:0]  RST_BUS_CLOCK_CONTROL  = 7'h7f;
    localparam logic [7:0]  RST_SERIAL_FORMAT      = 8'h00;
    localparam logic [15:0] RST_TRIGGER_SELECT     = 16'h0000;
    localparam int          SERIAL_PHASES          = 17;
    localparam int          SERIAL_IRQS            = 16;
    localparam int          FMT_CONTINUOUS_BIT     = 7;
    localparam int          FMT_START_WIDTH_LO     = 0;
    localparam logic [1:0]  RST_START_WIDTH        = 2'h0;
    localparam logic [2:0]  START_CLOCKS_BASE      = 3'h4;
    localparam logic [7:0]  IDLE_GAP_CLOCKS        = 8'h08;
    localparam logic [2:0]  CLK_DIV_FAST           = 3'h2;
    localparam logic [2:0]  CLK_DIV_SLOW           = 3'h4;
    localparam logic [6:0]  TLP_FMT_MWR32          = 7'h40;
    localparam logic [6:0]  TLP_FMT_MWR64          = 7'h60;

    typedef enum logic [2:0] {
        SIM_IDLE,
        SIM_START,
        SIM_RECOVER,
        SIM_FRAME,
        SIM_STOP,
        SIM_GAP
    } sim_ser_e;

    typedef struct packed {
        logic        fmt64;
        logic [63:0] address;
        logic [15:0] data;
        logic [3:0]  vector;
    } sim_msi_s;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [3:0] be;
        logic [31:0] wdata;
    } sim_cfg_s;

endpackage

// ===== rtl/sim_bridge.sv
`timescale 1ns/1ps
`default_nettype none
module sim_bridge
    import sim_pkg::*;
(
    input  wire logic        I_MCLK,
    input  wire logic        I_RST,
    input  wire logic        I_CE,
    input  wire logic        I_CFG_WR,
    input  wire logic        I_CFG_RD,
    input  wire logic [7:0]  I_CFG_ADDR,
    input  wire logic [3:0]  I_CFG_BE,
    input  wire logic [31:0] I_CFG_WDATA,
    output logic      [31:0] O_CFG_RDATA,
    output logic             O_CFG_ACK,
    input  wire logic        I_SERIAL_LINE,
    output logic             O_SERIAL_LINE,
    output logic             O_SERIAL_LINE_OE,
    input  wire logic        I_FAST_BUS_FREQUENCY_SELECT,
    output logic      [6:0]  O_BUS_CLOCK_OUTPUTS,
    output logic             O_MSI_VALID,
    input  wire logic        I_MSI_READY,
    output logic             O_MSI_FMT64,
    output logic      [63:0] O_MSI_ADDRESS,
    output logic      [6:0]  O_MSI_TLP_FMT_TYPE,
    output logic      [31:0] O_MSI_PAYLOAD
);

    // ************************************************************
    // pin synchronisers
    // ************************************************************
    logic [1:0] ser_sync_q;
    logic [1:0] fsel_sync_q;

    always_ff @(posedge I_MCLK or posedge I_RST)
    begin
        if (I_RST)
        begin
            ser_sync_q  <= 2'h3;
            fsel_sync_q <= 2'h0;
        end
        else if (I_CE)
        begin
            ser_sync_q  <= {ser_sync_q[0], I_SERIAL_LINE};
            fsel_sync_q <= {fsel_sync_q[0], I_FAST_BUS_FREQUENCY_SELECT};
        end
    end

    wire logic ser_in = ser_sync_q[1];
    wire logic fast_sel = fsel_sync_q[1];

    // ************************************************************
    // configuration registers
    // ************************************************************
    logic [15:0] command_word_q;
    logic        single_vector_irq_enable_q;
    logic [2:0]  multi_vector_count_q;
    logic [31:0] msi_address_low_q;
    logic [31:0] msi_address_high_q;
    logic [15:0] msi_data_value_q;
    logic [6:0]  bus_clock_output_control_q;
    logic [7:0]  serial_interrupt_format_q;
    logic [15:0] serial_interrupt_trigger_select_q;
    logic [15:0] serial_interrupt_level_status_q;
    logic [15:0] level_status_d;
    logic [15:0] status_clear;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a[7:2] == ofs[7:2]);
    endfunction

    wire logic wr = I_CE && I_CFG_WR;

    always_ff @(posedge I_MCLK or posedge I_RST)
    begin
        if (I_RST)
        begin
            command_word_q                    <= 16'h0000;
            single_vector_irq_enable_q        <= 1'b0;
            multi_vector_count_q              <= 3'h0;
            msi_address_low_q                 <= 32'h0000_0000;
            msi_address_high_q                <= 32'h0000_0000;
            msi_data_value_q                  <= 16'h0000;
            serial_interrupt_format_q         <= RST_SERIAL_FORMAT;
            serial_interrupt_trigger_select_q <= RST_TRIGGER_SELECT;
        end
        else if (wr)
        begin
            if (hit(I_CFG_ADDR, OFS_COMMAND_WORD))
            begin
                if (I_CFG_BE[0]) command_word_q[7:0]  <= I_CFG_WDATA[7:0];
                if (I_CFG_BE[1]) command_word_q[15:8] <= I_CFG_WDATA[15:8];
            end
            // enable bits in upper half of word 60h
            if (hit(I_CFG_ADDR, OFS_MSI_CONTROL) && I_CFG_BE[2])
            begin
                single_vector_irq_enable_q <= I_CFG_WDATA[16 + POS_SINGLE_VECTOR_EN];
                multi_vector_count_q <= I_CFG_WDATA[16 + POS_MULTI_VECTOR_LO +: 3];
            end
            if (hit(I_CFG_ADDR, OFS_MSI_ADDRESS_LOW))
                msi_address_low_q <= {I_CFG_WDATA[31:2], 2'h0};
            if (hit(I_CFG_ADDR, OFS_MSI_ADDRESS_HIGH))
                msi_address_high_q <= I_CFG_WDATA;
            if (hit(I_CFG_ADDR, OFS_MSI_DATA_VALUE) && I_CFG_BE[0])
                msi_data_value_q[7:0] <= I_CFG_WDATA[7:0];
            if (hit(I_CFG_ADDR, OFS_MSI_DATA_VALUE) && I_CFG_BE[1])
                msi_data_value_q[15:8] <= I_CFG_WDATA[15:8];
            if (hit(I_CFG_ADDR, OFS_SERIAL_FORMAT) && I_CFG_BE[0])
                serial_interrupt_format_q <= I_CFG_WDATA[7:0];
            if (hit(I_CFG_ADDR, OFS_SERIAL_FORMAT) && I_CFG_BE[2])
                serial_interrupt_trigger_select_q[7:0] <= I_CFG_WDATA[23:16];
            if (hit(I_CFG_ADDR, OFS_SERIAL_FORMAT) && I_CFG_BE[3])
                serial_interrupt_trigger_select_q[15:8] <= I_CFG_WDATA[31:24];
        end
    end

    // clock enables all on after reset
    always_ff @(posedge I_MCLK or posedge I_RST)
    begin
        if (I_RST)
            bus_clock_output_control_q <= RST_BUS_CLOCK_CONTROL;
        else if (wr && hit(I_CFG_ADDR, OFS_BUS_CLOCK_CONTROL) && I_CFG_BE[0])
            bus_clock_output_control_q <= I_CFG_WDATA[6:0];
    end

    // status is write-one-to-clear
    always_comb
    begin
        status_clear = 16'h0000;
        if (wr && hit(I_CFG_ADDR, OFS_LEVEL_STATUS))
            status_clear = I_CFG_WDATA[15:0] & {{8{I_CFG_BE[1]}}, {8{I_CFG_BE[0]}}};
    end

    // ************************************************************
    // serial interrupt stream
    // ************************************************************
    sim_ser_e    ser_state_q;
    logic [7:0]  ser_cnt_q;
    logic [4:0]  phase_q;
    logic [1:0]  slot_q;
    logic [15:0] frame_sample_q;
    logic [15:0] prev_sample_q;
    logic        frame_done_q;
    logic [2:0]  start_len;

    assign start_len = START_CLOCKS_BASE +
        {1'b0, serial_interrupt_format_q[FMT_START_WIDTH_LO +: 2]};

    // continuous vs quiet mode, start width
    // fixed seventeen phases, three clocks each
    always_ff @(posedge I_MCLK or posedge I_RST)
    begin
        if (I_RST)
        begin
            ser_state_q      <= SIM_IDLE;
            ser_cnt_q        <= 8'h00;
            phase_q          <= 5'h00;
            slot_q           <= 2'h0;
            frame_sample_q   <= 16'hffff;
            frame_done_q     <= 1'b0;
            O_SERIAL_LINE    <= 1'b1;
            O_SERIAL_LINE_OE <= 1'b0;
        end
        else if (I_CE)
        begin
            frame_done_q <= 1'b0;
            case (ser_state_q)
                SIM_IDLE:
                begin
                    O_SERIAL_LINE_OE <= 1'b0;
                    if (serial_interrupt_format_q[FMT_CONTINUOUS_BIT] || !ser_in)
                    begin
                        ser_state_q      <= SIM_START;
                        ser_cnt_q        <= 8'h00;
                        O_SERIAL_LINE    <= 1'b0;
                        O_SERIAL_LINE_OE <= 1'b1;
                    end
                end
                SIM_START:
                begin
                    ser_cnt_q <= ser_cnt_q + 8'h01;
                    if (ser_cnt_q[2:0] == start_len - 3'h1)
                    begin
                        O_SERIAL_LINE <= 1'b1;
                        ser_state_q   <= SIM_RECOVER;
                    end
                end
                SIM_RECOVER:
                begin
                    O_SERIAL_LINE_OE <= 1'b0;
                    ser_state_q      <= SIM_FRAME;
                    phase_q          <= 5'h00;
                    slot_q           <= 2'h0;
                end
                SIM_FRAME:
                begin
                    // frame 16 not sampled
                    // the synchroniser lags two clocks, so the last slot sees the first
                    if (slot_q == 2'h2 && phase_q < 5'(SERIAL_IRQS))
                        frame_sample_q[phase_q[3:0]] <= ser_in;
                    slot_q <= (slot_q == 2'h2) ? 2'h0 : slot_q + 2'h1;
                    if (slot_q == 2'h2)
                    begin
                        if (phase_q == 5'(SERIAL_PHASES - 1))
                        begin
                            ser_state_q      <= SIM_STOP;
                            ser_cnt_q        <= 8'h00;
                            O_SERIAL_LINE    <= 1'b0;
                            O_SERIAL_LINE_OE <= 1'b1;
                        end
                        phase_q <= phase_q + 5'h01;
                    end
                end
                SIM_STOP:
                begin
                    ser_cnt_q <= ser_cnt_q + 8'h01;
                    if (ser_cnt_q == 8'h01)
                    begin
                        O_SERIAL_LINE <= 1'b1;
                        frame_done_q  <= 1'b1;
                        ser_state_q   <= SIM_GAP;
                        ser_cnt_q     <= 8'h00;
                    end
                end
                SIM_GAP:
                begin
                    O_SERIAL_LINE_OE <= 1'b0;
                    ser_cnt_q        <= ser_cnt_q + 8'h01;
                    if (ser_cnt_q == IDLE_GAP_CLOCKS)
                        ser_state_q <= SIM_IDLE;
                end
                default:
                    ser_state_q <= SIM_IDLE;
            endcase
        end
    end

    // ************************************************************
    // event detection: low on the line means asserted
    // ************************************************************
    logic [15:0] asserted;
    logic [15:0] edge_event;
    logic [15:0] level_rise;
    logic [15:0] pending_q;
    logic [15:0] grant_mask;

    assign asserted = ~frame_sample_q;

    always_ff @(posedge I_MCLK or posedge I_RST)
    begin
        if (I_RST)
            prev_sample_q <= 16'h0000;
        else if (I_CE && frame_done_q)
            prev_sample_q <= asserted;
    end

    assign edge_event = (frame_done_q ? (asserted & ~prev_sample_q) : 16'h0000)
                        & serial_interrupt_trigger_select_q;

    // set wins over a same-cycle clear
    always_comb
    begin
        level_status_d = serial_interrupt_level_status_q & ~status_clear;
        if (frame_done_q)
            level_status_d = level_status_d | (asserted & ~serial_interrupt_trigger_select_q);
    end

    always_ff @(posedge I_MCLK or posedge I_RST)
    begin
        if (I_RST)
            serial_interrupt_level_status_q <= 16'h0000;
        else if (I_CE)
            serial_interrupt_level_status_q <= level_status_d;
    end

    assign level_rise = level_status_d & ~serial_interrupt_level_status_q
                        & ~serial_interrupt_trigger_select_q;

    // events wait here until a message is started for them
    always_ff @(posedge I_MCLK or posedge I_RST)
    begin
        if (I_RST)
            pending_q <= 16'h0000;
        else if (I_CE)
            pending_q <= (pending_q & ~grant_mask) | (I_CE ? (edge_event | level_rise) : 16'h0000);
    end

    // ************************************************************
    // message generation
    // ************************************************************
    logic [3:0]  pick;
    logic        msi_allowed;
    logic [3:0]  vec_mask;

    always_comb
    begin
        pick = 4'h0;
        for (int i = SERIAL_IRQS - 1; i >= 0; i--)
            if (pending_q[i])
                pick = 4'(i);
    end

    assign msi_allowed = command_word_q[POS_BUS_MASTER_ENABLE] && single_vector_irq_enable_q;
    assign grant_mask = (I_CE && msi_allowed && !O_MSI_VALID && pending_q != 16'h0000)
                        ? (16'h0001 << pick) : 16'h0000;

    always_comb
    begin
        case (multi_vector_count_q)
            3'h0:    vec_mask = 4'h0;
            3'h1:    vec_mask = 4'h1;
            3'h2:    vec_mask = 4'h3;
            3'h3:    vec_mask = 4'h7;
            default: vec_mask = 4'hf;
        endcase
    end

    always_ff @(posedge I_MCLK or posedge I_RST)
    begin
        if (I_RST)
        begin
            O_MSI_VALID        <= 1'b0;
            O_MSI_FMT64        <= 1'b0;
            O_MSI_ADDRESS      <= 64'h0;
            O_MSI_TLP_FMT_TYPE <= 7'h00;
            O_MSI_PAYLOAD      <= 32'h0;
        end
        else if (I_CE)
        begin
            if (O_MSI_VALID && I_MSI_READY)
                O_MSI_VALID <= 1'b0;
            else if (grant_mask != 16'h0000)
            begin
                O_MSI_VALID <= 1'b1;
                O_MSI_FMT64 <= (msi_address_high_q != 32'h0);
                O_MSI_TLP_FMT_TYPE <= (msi_address_high_q != 32'h0) ? TLP_FMT_MWR64 : TLP_FMT_MWR32;
                O_MSI_ADDRESS <= {msi_address_high_q, msi_address_low_q};
                // byte 0 value, byte 1 vector
                O_MSI_PAYLOAD <= {16'h0000, 4'h0, pick & vec_mask, msi_data_value_q[7:0]};
            end
        end
    end

    // ************************************************************
    // bus clock outputs
    // ************************************************************
    logic [2:0] div_cnt_q;
    logic       clk_phase_q;
    logic [2:0] div_half;

    // half period from the frequency select
    assign div_half = fast_sel ? CLK_DIV_FAST : CLK_DIV_SLOW;

    // everything here runs on I_MCLK
    always_ff @(posedge I_MCLK or posedge I_RST)
    begin
        if (I_RST)
        begin
            div_cnt_q   <= 3'h0;
            clk_phase_q <= 1'b0;
        end
        else if (I_CE)
        begin
            if (div_cnt_q >= div_half - 3'h1)
            begin
                div_cnt_q   <= 3'h0;
                clk_phase_q <= ~clk_phase_q;
            end
            else
                div_cnt_q <= div_cnt_q + 3'h1;
        end
    end

    always_ff @(posedge I_MCLK or posedge I_RST)
    begin
        if (I_RST)
            O_BUS_CLOCK_OUTPUTS <= 7'h00;
        else if (I_CE)
            O_BUS_CLOCK_OUTPUTS <= {7{clk_phase_q}} & bus_clock_output_control_q;
    end

    // ************************************************************
    // configuration read
    // ************************************************************
    always_ff @(posedge I_MCLK or posedge I_RST)
    begin
        if (I_RST)
        begin
            O_CFG_RDATA <= 32'h0;
            O_CFG_ACK   <= 1'b0;
        end
        else if (I_CE)
        begin
            O_CFG_ACK <= I_CFG_RD || I_CFG_WR;
            if (I_CFG_RD)
            begin
                O_CFG_RDATA <= 32'h0;
                if (hit(I_CFG_ADDR, OFS_COMMAND_WORD))
                    O_CFG_RDATA <= {16'h0000, command_word_q};
                if (hit(I_CFG_ADDR, OFS_MSI_CONTROL))
                    O_CFG_RDATA <= {8'h00, 1'b0, multi_vector_count_q, MULTI_VECTOR_CAPABLE,
                                    single_vector_irq_enable_q, 16'h0000};
                if (hit(I_CFG_ADDR, OFS_MSI_ADDRESS_LOW))
                    O_CFG_RDATA <= msi_address_low_q;
                if (hit(I_CFG_ADDR, OFS_MSI_ADDRESS_HIGH))
                    O_CFG_RDATA <= msi_address_high_q;
                if (hit(I_CFG_ADDR, OFS_MSI_DATA_VALUE))
                    O_CFG_RDATA <= {16'h0000, msi_data_value_q};
                if (hit(I_CFG_ADDR, OFS_BUS_CLOCK_CONTROL))
                    O_CFG_RDATA <= {25'h0, bus_clock_output_control_q};
                if (hit(I_CFG_ADDR, OFS_SERIAL_FORMAT))
                    O_CFG_RDATA <= {serial_interrupt_trigger_select_q, 8'h00, serial_interrupt_format_q};
                if (hit(I_CFG_ADDR, OFS_LEVEL_STATUS))
                    O_CFG_RDATA <= {16'h0000, serial_interrupt_level_status_q};
            end
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    a_no_msi_disabled: assert property (@(posedge I_MCLK) disable iff (I_RST)
        $rose(O_MSI_VALID) |-> $past(msi_allowed))
        else $error("message started while disabled");
    a_fmt_follows_high: assert property (@(posedge I_MCLK) disable iff (I_RST)
        $rose(O_MSI_VALID) |-> O_MSI_FMT64 == ($past(msi_address_high_q) != 32'h0))
        else $error("address size wrong");
    a_vector_alias: assert property (@(posedge I_MCLK) disable iff (I_RST)
        O_MSI_VALID |-> (O_MSI_PAYLOAD[15:8] & ~{4'h0, vec_mask}) == 8'h00 || $changed(multi_vector_count_q))
        else $error("vector outside enabled count");
    a_clocks_gated: assert property (@(posedge I_MCLK) disable iff (I_RST)
        (O_BUS_CLOCK_OUTPUTS & ~$past(bus_clock_output_control_q)) == 7'h00)
        else $error("disabled clock output toggled");

    sequence s_msi_waiting;
        O_MSI_VALID && !I_MSI_READY;
    endsequence
    a_msi_held: assert property (@(posedge I_MCLK) disable iff (I_RST)
        s_msi_waiting |=> O_MSI_VALID && $stable(O_MSI_PAYLOAD) && $stable(O_MSI_ADDRESS))
        else $error("message changed before it was taken");

    sequence s_last_slot;
        I_CE && ser_state_q == SIM_FRAME && phase_q == 5'(SERIAL_PHASES - 1) && slot_q == 2'h2;
    endsequence
    a_frame_length: assert property (@(posedge I_MCLK) disable iff (I_RST)
        s_last_slot |=> ser_state_q == SIM_STOP && !O_SERIAL_LINE && O_SERIAL_LINE_OE)
        else $error("serial frame length wrong");

endmodule
`default_nettype wire

// ===== sim/sim_far_side.sv
`timescale 1ns/1ps
`default_nettype none
module sim_far_side
(
    input  wire logic        i_clk,
    input  wire logic        i_drv,
    input  wire logic        i_oe,
    input  wire logic [16:0] i_irq,
    input  wire logic        i_slow,
    output logic             o_line,
    output logic             o_ready
);
    logic       arm_q = 1'b0;
    logic [5:0] cnt_q = 6'h00;
    logic [2:0] stl_q = 3'h0;
    logic [2:0] low_q = 3'h0;
    always_ff @(posedge i_clk)
    begin
        stl_q <= stl_q + 3'h1;
        cnt_q <= i_oe ? 6'h00 : cnt_q + 6'(arm_q);
        // only the long start pulse arms the slots, never the two-clock stop
        low_q <= (i_oe && !i_drv) ? low_q + 3'(low_q != 3'h7) : 3'h0;
        if (low_q == 3'h3)
            arm_q <= 1'b1;
        else if (cnt_q == 6'h32)
            arm_q <= 1'b0;
    end
    assign o_line  = i_oe ? i_drv : !(arm_q && i_irq[cnt_q / 6'h03]);
    // a slow root holds ready off seven cycles in eight
    assign o_ready = !i_slow || stl_q == 3'h0;
endmodule
`default_nettype wire

// ===== sim/test_sim_bridge.sv
`timescale 1ns/1ps
`default_nettype none
module test_sim_bridge
    import sim_pkg::*;
;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        fsel = 1'b0;
    logic        slow = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [3:0]  be = 4'h0;
    logic [31:0] wd = 32'h0;
    logic [31:0] ah = 32'h0;
    logic [16:0] irq = 17'h0;
    logic [31:0] rdat, pay, al, dv;
    logic [63:0] madr;
    logic [6:0]  cko, tt;
    logic        ack, s_o, s_oe, s_in, msi_v, rdy, f64;
    logic [64:0] e;
    logic [64:0] rq[$];
    logic [87:0] mq[$];
    int          miscompares = 0;
    int          comparisons = 0;
    int          cyc = 0;
    int          n;

    sim_bridge i_sim_bridge (.I_MCLK(clk), .I_RST(rst), .I_CE(1'b1), .I_CFG_WR(wr), .I_CFG_RD(rd),
        .I_CFG_ADDR(adr), .I_CFG_BE(be), .I_CFG_WDATA(wd), .O_CFG_RDATA(rdat), .O_CFG_ACK(ack),
        .I_SERIAL_LINE(s_in), .O_SERIAL_LINE(s_o), .O_SERIAL_LINE_OE(s_oe), .I_MSI_READY(rdy),
        .I_FAST_BUS_FREQUENCY_SELECT(fsel), .O_BUS_CLOCK_OUTPUTS(cko), .O_MSI_VALID(msi_v),
        .O_MSI_FMT64(f64), .O_MSI_ADDRESS(madr), .O_MSI_TLP_FMT_TYPE(tt), .O_MSI_PAYLOAD(pay));
    sim_far_side i_sim_far_side (.i_clk(clk), .i_drv(s_o), .i_oe(s_oe), .i_irq(irq),
        .i_slow(slow), .o_line(s_in), .o_ready(rdy));

    initial
        forever #25 clk = !clk;

    // ****************
    // tasks
    // ****************
    task automatic check(input logic [87:0] seen, input logic [87:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic complete_run();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // reads note mask and expected word; writes note nothing to compare
    task automatic cfg(input logic w, input logic [7:0] a, input logic [3:0] b, input logic [31:0] d,
                       input logic [31:0] m = 32'h0, input logic [31:0] x = 32'h0);
        rq.push_back({!w, m, x});
        @(negedge clk);
        wr = w;
        rd = !w;
        adr = a;
        be = b;
        wd = d;
        @(negedge clk);
        wr = 1'b0;
        rd = 1'b0;
    endtask

    function automatic logic [87:0] ex(input int q, input int m);
        logic [3:0] v;
        v = 4'(q & ((1 << (m > 4 ? 4 : m)) - 1));
        return {ah != 0 ? TLP_FMT_MWR64 : TLP_FMT_MWR32, ah != 0, ah, al, 4'h0, v, dv[7:0]};
    endfunction

    // held 200 clocks on, 200 off (a frame is 68), so one whole frame is always seen
    task automatic pulse(input int q, input int m);
        if (m >= 0)
            mq.push_back(ex(q, m));
        irq = 17'(1 << q);
        repeat (200) @(negedge clk);
        irq = 17'h0;
        repeat (200) @(negedge clk);
    endtask

    task automatic rate(input int x);
        int   t;
        logic p;
        t = 0;
        repeat (8) @(negedge clk);
        p = cko[0];
        repeat (16)
        begin
            @(negedge clk);
            t += int'(cko[0] !== p);
            p = cko[0];
        end
        check(t, x);
    endtask

    always @(posedge clk)
    begin
        cyc++;
        if (ack === 1'b1)
        begin
            e = rq.pop_front();
            if (e[64])
                check(rdat & e[63:32], e[31:0]);
        end
        if (msi_v === 1'b1 && rdy === 1'b1)
            check({tt, f64, madr, pay[15:0]}, mq.size() ? mq.pop_front() : '1);
        if (cyc == 10000)
        begin
            miscompares++;
            complete_run();
        end
    end

    initial
    begin
        n = $urandom(52);
        repeat (6) @(negedge clk);
        rst = 1'b0;
        al = $urandom & 32'hfffffffc;
        dv = $urandom;
        cfg(1'b0, OFS_BUS_CLOCK_CONTROL, 4'hf, 0, 32'h7f, 32'h7f);
        cfg(1'b0, OFS_SERIAL_FORMAT, 4'hf, 0, 32'hffff00ff, 0);
        cfg(1'b0, 8'h10, 4'hf, 0, '1, 0);
        cfg(1'b1, OFS_MSI_ADDRESS_LOW, 4'hf, al);
        cfg(1'b1, OFS_MSI_DATA_VALUE, 4'h3, dv);
        cfg(1'b1, OFS_SERIAL_FORMAT, 4'hf, 32'hffff0080);
        cfg(1'b0, OFS_MSI_ADDRESS_LOW, 4'hf, 0, '1, al);
        $display("test registers done");
        cfg(1'b1, 8'h60, 4'hc, 32'h00010000);
        pulse(3, -1);
        mq.push_back(ex(3, 0));
        cfg(1'b1, OFS_COMMAND_WORD, 4'h3, 32'h4);
        repeat (50) @(negedge clk);
        check(mq.size(), 0);
        $display("test enable gating done");
        for (int m = 0; m < 6; m++)
        begin
            slow = m[0];
            cfg(1'b1, 8'h60, 4'hc, 32'h00010000 | 32'(m << 20));
            n = $urandom % 16;
            pulse(n, m);
        end
        pulse(16, -1);
        ah = $urandom | 32'h1;
        cfg(1'b1, OFS_MSI_ADDRESS_HIGH, 4'hf, ah);
        pulse(9, 5);
        check(mq.size(), 0);
        $display("test edge mode done");
        cfg(1'b1, OFS_SERIAL_FORMAT, 4'hf, 32'h00000080);
        n = $urandom % 16;
        pulse(n, 5);
        cfg(1'b0, OFS_LEVEL_STATUS, 4'hf, 0, 32'hffff, 32'(1 << n));
        cfg(1'b1, OFS_LEVEL_STATUS, 4'h3, 32'(1 << n));
        cfg(1'b0, OFS_LEVEL_STATUS, 4'hf, 0, 32'hffff, 0);
        check(mq.size(), 0);
        $display("test level mode done");
        fsel = 1'b1;
        rate(8);
        fsel = 1'b0;
        rate(4);
        cfg(1'b1, OFS_BUS_CLOCK_CONTROL, 4'h1, 0);
        rate(0);
        $display("test bus clocks done");
        complete_run();
    end
endmodule
`default_nettype wire
